/* core/prsc_pkg.sv */
// constants and types shared by the parallel receive station control block
package prsc_pkg;
  // clock rate in hertz
  localparam longint unsigned CLK_HZ = 250_000_000;
  // on-hook timeout, seconds
  localparam longint unsigned HANGUP_TIME_S = 15;
  localparam longint unsigned HANGUP_CYCLES = HANGUP_TIME_S * CLK_HZ;
  // character delay window in microseconds; the least figure is used
  localparam longint unsigned CHAR_DELAY_MIN_US = 1800;
  localparam longint unsigned CHAR_DELAY_MAX_US = 4000;
  localparam longint unsigned CHAR_DELAY_CYCLES =
    (CHAR_DELAY_MIN_US * CLK_HZ + 999_999) / 1_000_000;
  // character ready pulse width, microseconds
  localparam longint unsigned PULSE_TIME_US = 30;
  localparam longint unsigned PULSE_CYCLES = PULSE_TIME_US * CLK_HZ / 1_000_000;

  // register byte offsets
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] COUNT_OFFSET = 8'h08;
  // control fields and reset value
  localparam int CTRL_NORMAL_BIT = 0;
  localparam logic CTRL_NORMAL_RESET = 1'h1;
  // status fields
  localparam int ST_DTR_BIT = 0;
  localparam int ST_TIMER_OK_BIT = 1;
  localparam int ST_TIMER_RUN_BIT = 2;
  localparam int ST_DCD_BIT = 3;
  localparam int ST_DSR_BIT = 4;
  localparam int ST_RM_BIT = 5;
  localparam int ST_PRN_READY_BIT = 6;
  localparam int ST_CHR_BUSY_BIT = 7;

  // positions of the lead inputs in the synchroniser vector
  localparam int LEAD_RM = 0;
  localparam int LEAD_DSR = 1;
  localparam int LEAD_DCD = 2;
  localparam int LEAD_PRN_READY = 3;
  localparam int LEAD_GEN_READY = 4;
  localparam int LEAD_PAPER_LOW = 5;
  localparam int LEAD_TIMING = 6;
  localparam int LEAD_COUNT = 7;
  // idle level of each lead while held in reset
  localparam logic [6:0] LEAD_INIT = 7'h4f;

  typedef enum logic [1:0] {
    CHR_IDLE,
    CHR_DELAY,
    CHR_PULSE,
    CHR_BLOCKED
  } prsc_chr_state_type;
endpackage

/* core/prsc_station_ctrl.sv */
// station control and parallel receive path with apb registers
//
// Overview of operation
// - drop dtr after carrier has been absent beyond the 15 second hangup time
// - dsr going off at call end resets the hangup timer
// - message receive lead reaches printer turn-on only in normal position
// - dtr on needs general ready high, paper low off until dsr is on, timer not expired
// - low paper blocks dtr before a call, not once a call is up
// - after reset the hangup timer shows not expired
// - message receive lead turns printer on and releases the hangup timer
// - printer ready drives reverse channel ok low toward the data set
// - carrier on clears and stops timer and enables the pulse gate
// - timer expiry turns dtr off so the call is dropped
// - timing fall with carrier starts a 1.8 to 4.0 ms delay, then pulse
// - character ready pulse is low for about 30 us
// - one pulse only while the timing lead stays low
// - timing lead going high re-arms the pulse generator
// - low data input gives mark high output, open input gives space low
// - carrier off enables the hangup timer; expiry releases dtr
// - data outputs last as long as the timing strobe
//
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/1ps
module prsc_station_ctrl
  import prsc_pkg::*;
#(
  parameter longint unsigned HANGUP_CNT = HANGUP_CYCLES,
  parameter longint unsigned DELAY_CNT = CHAR_DELAY_CYCLES,
  parameter longint unsigned PULSE_CNT = PULSE_CYCLES,
  parameter int ADDR_W = 8,
  parameter int DATA_BITS = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic message_receive_lead_n,
  input wire logic dsr_n,
  input wire logic dcd_n,
  input wire logic printer_ready_n,
  input wire logic general_ready,
  input wire logic paper_low,
  input wire logic char_timing_n,
  input wire logic [DATA_BITS-1:0] data_in_n,
  output logic dtr_n,
  output logic printer_turn_on_n,
  output logic reverse_channel_ok_n,
  output logic char_ready_pulse_n,
  output logic [DATA_BITS-1:0] data_out
);
  localparam int IN_W = LEAD_COUNT + DATA_BITS;
  localparam logic [IN_W-1:0] SYNC_INIT = {{DATA_BITS{1'b1}}, LEAD_INIT};
  localparam logic [31:0] HANG_LAST = 32'(HANGUP_CNT - 1);
  localparam logic [19:0] DELAY_LAST = 20'(DELAY_CNT - 1);
  localparam logic [12:0] PULSE_LAST = 13'(PULSE_CNT - 1);

  logic [IN_W-1:0] pins_raw;
  logic [IN_W-1:0] sync1_q;
  logic [IN_W-1:0] sync2_q;
  logic rm_on;
  logic dsr_on;
  logic dcd_on;
  logic prn_ready;
  logic timing_on;
  logic timing_prev_q;
  logic timing_fall;
  logic [DATA_BITS-1:0] data_mark;
  logic normal_q;
  logic hangup_ok_q;
  logic [31:0] hang_cnt_q;
  logic hang_run;
  logic dtr_on_d;
  prsc_chr_state_type chr_state_q;
  prsc_chr_state_type chr_state_d;
  logic [19:0] dly_cnt_q;
  logic [12:0] pls_cnt_q;
  logic [15:0] char_count_q;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic [7:0] reg_addr;
  logic mapped;

  // every lead crosses two flops before use; pins are asynchronous
  assign pins_raw = {data_in_n, char_timing_n, paper_low, general_ready,
                     printer_ready_n, dcd_n, dsr_n, message_receive_lead_n};

  for (genvar i = 0; i < IN_W; i++) begin : g_sync
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        sync1_q[i] <= SYNC_INIT[i];
        sync2_q[i] <= SYNC_INIT[i];
      end else begin
        sync1_q[i] <= pins_raw[i];
        sync2_q[i] <= sync1_q[i];
      end
    end
  end

  // positive-sense views of the synchronised leads
  assign rm_on = !sync2_q[LEAD_RM];
  assign dsr_on = !sync2_q[LEAD_DSR];
  assign dcd_on = !sync2_q[LEAD_DCD];
  assign prn_ready = !sync2_q[LEAD_PRN_READY];
  assign timing_on = !sync2_q[LEAD_TIMING];
  assign data_mark = ~sync2_q[IN_W-1:LEAD_COUNT];

  // previous timing level for edge detection
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      timing_prev_q <= 1'b0;
    end else begin
      timing_prev_q <= timing_on;
    end
  end
  assign timing_fall = timing_on && !timing_prev_q;

  // hangup timer runs after message receive while carrier is absent
  assign hang_run = rm_on && !dcd_on && hangup_ok_q;

  // counter is cleared while carrier is on or when the call is gone
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hang_cnt_q <= 32'h0000_0000;
    end else if (!dsr_on || dcd_on || !rm_on) begin
      hang_cnt_q <= 32'h0000_0000;
    end else if (hang_run) begin
      hang_cnt_q <= hang_cnt_q + 32'h0000_0001;
    end
  end

  // not-expired flag; dsr dropping at call end restores it
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hangup_ok_q <= 1'b1;
    end else if (!dsr_on) begin
      hangup_ok_q <= 1'b1;
    end else if (hang_run && hang_cnt_q == HANG_LAST) begin
      hangup_ok_q <= 1'b0;
    end
  end

  // low paper only matters until the data set has the call up
  // leads read directly so the assignment wakes on every change of them
  assign dtr_on_d = sync2_q[LEAD_GEN_READY] && hangup_ok_q &&
                    (!sync2_q[LEAD_PAPER_LOW] || dsr_on);

  // station leads toward data set and printer, all registered
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dtr_n <= 1'b1;
      printer_turn_on_n <= 1'b1;
      reverse_channel_ok_n <= 1'b1;
    end else begin
      dtr_n <= !dtr_on_d;
      printer_turn_on_n <= !(rm_on && normal_q);
      reverse_channel_ok_n <= !prn_ready;
    end
  end

  // character pulse sequencer
  always_comb begin
    chr_state_d = chr_state_q;
    unique case (chr_state_q)
      CHR_IDLE: begin
        if (timing_fall && dcd_on) begin
          chr_state_d = CHR_DELAY;
        end
      end
      CHR_DELAY: begin
        // a strobe that ends early or a lost carrier abandons the character
        if (!timing_on || !dcd_on) begin
          chr_state_d = CHR_IDLE;
        end else if (dly_cnt_q == DELAY_LAST) begin
          chr_state_d = CHR_PULSE;
        end
      end
      CHR_PULSE: begin
        if (pls_cnt_q == PULSE_LAST) begin
          chr_state_d = timing_on ? CHR_BLOCKED : CHR_IDLE;
        end
      end
      CHR_BLOCKED: begin
        if (!timing_on) begin
          chr_state_d = CHR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      chr_state_q <= CHR_IDLE;
    end else begin
      chr_state_q <= chr_state_d;
    end
  end

  // delay and width counters only advance in their own state
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dly_cnt_q <= 20'h00000;
      pls_cnt_q <= 13'h0000;
    end else begin
      dly_cnt_q <= (chr_state_q == CHR_DELAY) ? dly_cnt_q + 20'h00001 : 20'h00000;
      pls_cnt_q <= (chr_state_q == CHR_PULSE) ? pls_cnt_q + 13'h0001 : 13'h0000;
    end
  end

  // pulse output follows the next state so it lines up with the state
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      char_ready_pulse_n <= 1'b1;
    end else begin
      char_ready_pulse_n <= (chr_state_d != CHR_PULSE);
    end
  end

  // data shown only while the strobe is on, so the pulse sits mid-data
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_out <= '0;
    end else begin
      data_out <= timing_on ? data_mark : '0;
    end
  end

  // characters delivered, wraps silently
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      char_count_q <= 16'h0000;
    end else if (chr_state_q == CHR_DELAY && chr_state_d == CHR_PULSE) begin
      char_count_q <= char_count_q + 16'h0001;
    end
  end

  // apb slave: zero wait states, error on unmapped offsets
  assign reg_addr = 8'(paddr);
  assign mapped = (reg_addr == CTRL_OFFSET) || (reg_addr == STATUS_OFFSET) ||
                  (reg_addr == COUNT_OFFSET);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // normal/test selection is the only writable bit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      normal_q <= CTRL_NORMAL_RESET;
    end else if (psel && penable && pwrite && reg_addr == CTRL_OFFSET && pstrb[0]) begin
      normal_q <= pwdata[CTRL_NORMAL_BIT];
    end
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[ST_DTR_BIT] = !dtr_n;
    status_word[ST_TIMER_OK_BIT] = hangup_ok_q;
    status_word[ST_TIMER_RUN_BIT] = hang_run;
    status_word[ST_DCD_BIT] = dcd_on;
    status_word[ST_DSR_BIT] = dsr_on;
    status_word[ST_RM_BIT] = rm_on;
    status_word[ST_PRN_READY_BIT] = prn_ready;
    status_word[ST_CHR_BUSY_BIT] = (chr_state_q != CHR_IDLE);
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (reg_addr == CTRL_OFFSET) begin
      rd_mux[CTRL_NORMAL_BIT] = normal_q;
    end else if (reg_addr == STATUS_OFFSET) begin
      rd_mux = status_word;
    end else if (reg_addr == COUNT_OFFSET) begin
      rd_mux = {16'h0000, char_count_q};
    end
  end

  // read data captured in the setup cycle, stable through the access
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // checks on the station and pulse logic
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  dtr_cause_a: assert property (!dtr_n |-> $past(dtr_on_d))
    else $error("dtr on without its three conditions");

  expiry_drop_a: assert property (!hangup_ok_q && dsr_on |=> dtr_n)
    else $error("dtr still on after timer expiry");

  timer_expire_a: assert property ($fell(hangup_ok_q) |-> $past(hang_cnt_q) == HANG_LAST)
    else $error("hangup timer expired at wrong count");

  dsr_reset_a: assert property (!dsr_on |=> hangup_ok_q && hang_cnt_q == 32'h0000_0000)
    else $error("timer not reset after dsr off");

  dcd_clamp_a: assert property (dcd_on |=> hang_cnt_q == 32'h0000_0000)
    else $error("timer not cleared while carrier on");

  timer_run_a: assert property (hang_run && dsr_on |=> hang_cnt_q == $past(hang_cnt_q) + 1 ||
                                 !hangup_ok_q)
    else $error("released timer did not advance");

  printer_on_a: assert property (rm_on && normal_q |=> !printer_turn_on_n)
    else $error("printer not turned on in normal position");

  test_block_a: assert property (!normal_q |=> printer_turn_on_n)
    else $error("printer turned on in test position");

  rev_chan_a: assert property (prn_ready |=> !reverse_channel_ok_n)
    else $error("reverse channel ok missing with printer ready");

  delay_len_a: assert property ($fell(char_ready_pulse_n) |-> $past(dly_cnt_q) == DELAY_LAST)
    else $error("character delay has wrong length");

  pulse_len_a: assert property ($rose(char_ready_pulse_n) |-> $past(pls_cnt_q) == PULSE_LAST)
    else $error("character pulse has wrong width");

  single_pulse_a: assert property (chr_state_q == CHR_BLOCKED && timing_on |=> char_ready_pulse_n)
    else $error("second pulse during one strobe");

  rearm_a: assert property (chr_state_q == CHR_BLOCKED && !timing_on |=> chr_state_q == CHR_IDLE)
    else $error("pulse generator not re-armed");

  data_mark_a: assert property (timing_on |=> data_out == $past(data_mark))
    else $error("data output not the inverted input");

  data_idle_a: assert property (!timing_on |=> data_out == '0)
    else $error("data output outside timing strobe");

  pulse_seen_c: cover property ($fell(char_ready_pulse_n));
  expiry_seen_c: cover property ($fell(hangup_ok_q) ##[1:4] dtr_n);
  call_up_c: cover property (!dtr_n && dsr_on && dcd_on);
  early_end_c: cover property (chr_state_q == CHR_DELAY && !timing_on);
endmodule

/* tb/prsc_dataset_model.sv */
// data set and printer model facing the station control block
`timescale 1ns/1ps
module prsc_dataset_model #(
  parameter int READY_LAG = 6
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic dtr_n,
  input wire logic printer_turn_on_n,
  input wire logic ring,
  input wire logic carrier,
  output logic dsr_n,
  output logic message_receive_lead_n,
  output logic dcd_n,
  output logic printer_ready_n
);
  int lag_q;
  // answer only while dtr is on; dtr off drops the call and opens dsr
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dsr_n <= 1'b1;
      message_receive_lead_n <= 1'b1;
    end else if (dtr_n) begin
      dsr_n <= 1'b1;
      message_receive_lead_n <= 1'b1;
    end else if (ring) begin
      dsr_n <= 1'b0;
      message_receive_lead_n <= 1'b0;
    end
  end
  // carrier only on an answered line, raised by the bench before the timeout
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) dcd_n <= 1'b1;
    else dcd_n <= ~(carrier & ~dsr_n);
  end
  // printer reports ready only after its motors spin up, so it is slow
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) lag_q <= 0;
    else if (printer_turn_on_n) lag_q <= 0;
    else if (lag_q < READY_LAG) lag_q <= lag_q + 1;
  end
  assign printer_ready_n = (lag_q < READY_LAG);
endmodule

/* tb/parallel_receive_station_control_tb.sv */
// testbench for the parallel receive station control block
`timescale 1ns/1ps
module parallel_receive_station_control_tb;
  import prsc_pkg::*;
  localparam longint unsigned HC = 200;
  localparam longint unsigned DC = 20;
  localparam longint unsigned PC = 5;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, dtr_n, ton_n, rco_n, crp_n;
  logic rm_n, dsr_n, dcd_n, prdy_n;
  logic general_ready = 1'b1, paper_low = 1'b0, ctim_n = 1'b1;
  logic ring = 1'b0, carrier = 1'b0;
  logic [7:0] din_n = 8'hff, dout;
  int err_total = 0, cmp_count = 0, n;

  always #2 core_clk = ~core_clk;

  prsc_station_ctrl #(.HANGUP_CNT(HC), .DELAY_CNT(DC), .PULSE_CNT(PC)) uut (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .message_receive_lead_n(rm_n), .dsr_n(dsr_n), .dcd_n(dcd_n),
    .printer_ready_n(prdy_n), .general_ready(general_ready),
    .paper_low(paper_low), .char_timing_n(ctim_n), .data_in_n(din_n),
    .dtr_n(dtr_n), .printer_turn_on_n(ton_n), .reverse_channel_ok_n(rco_n),
    .char_ready_pulse_n(crp_n), .data_out(dout));

  prsc_dataset_model partner (
    .core_clk(core_clk), .reset_n(reset_n), .dtr_n(dtr_n),
    .printer_turn_on_n(ton_n), .ring(ring), .carrier(carrier),
    .dsr_n(dsr_n), .message_receive_lead_n(rm_n), .dcd_n(dcd_n),
    .printer_ready_n(prdy_n));

  task automatic w(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("ERROR at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  // one apb transfer; waits for pready, only the watchdog bounds a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    chk({31'h0, pready}, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one character strobe held low well past delay plus pulse
  task automatic chr(input logic [7:0] d, input logic ex);
    int f;
    int wd;
    f = -1;
    wd = 0;
    @(posedge core_clk);
    din_n <= d;
    ctim_n <= 1'b0;
    for (int i = 0; i < DC + PC + 40; i++) begin
      w(1);
      if (crp_n === 1'b0) begin
        if (f < 0) f = i;
        wd++;
      end
    end
    chk({24'h0, dout}, {24'h0, ~d});
    chk(32'(wd), ex ? 32'(PC) : 32'h0);
    if (ex) chk(32'(f >= DC && f <= DC + 6), 32'h1);
    @(posedge core_clk);
    ctim_n <= 1'b1;
    w(6);
    chk({24'h0, dout}, 32'h0);
  endtask

  task automatic wdtr(input logic v, input int lim);
    n = 0;
    while (dtr_n !== v && n < lim) begin
      w(1);
      n++;
    end
  endtask

  task automatic close_out;
    $display("compares %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // watchdog: the whole sequence needs under two thousand cycles
  initial begin
    repeat (6000) @(posedge core_clk);
    err_total++;
    close_out;
  end

  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    w(6);
    chk({31'h0, dtr_n}, 32'h0);
    chk({29'h0, rco_n, crp_n, ton_n}, 32'h7);
    apb(1'b0, CTRL_OFFSET, 32'h0);
    chk({31'h0, rd[CTRL_NORMAL_BIT]}, {31'h0, CTRL_NORMAL_RESET});
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk({31'h0, rd[ST_TIMER_OK_BIT]}, 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    // before a call both printer leads gate dtr
    @(posedge core_clk);
    paper_low <= 1'b1;
    w(5);
    chk({31'h0, dtr_n}, 32'h1);
    @(posedge core_clk);
    paper_low <= 1'b0;
    general_ready <= 1'b0;
    w(5);
    chk({31'h0, dtr_n}, 32'h1);
    @(posedge core_clk);
    general_ready <= 1'b1;
    ring <= 1'b1;
    w(10);
    chk({31'h0, ton_n}, 32'h0);
    @(posedge core_clk);
    ring <= 1'b0;
    paper_low <= 1'b1;
    w(12);
    chk({30'h0, rco_n, dtr_n}, 32'h0);
    @(posedge core_clk);
    paper_low <= 1'b0;
    carrier <= 1'b1;
    // sender keeps characters back for a while after carrier comes on
    w(HC + 50);
    chk({31'h0, dtr_n}, 32'h0);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk({31'h0, rd[ST_TIMER_RUN_BIT]}, 32'h0);
    chr(8'h5a, 1'b1);
    chr(8'h00, 1'b1);
    // strobe released before the delay ends must give no character
    @(posedge core_clk);
    ctim_n <= 1'b0;
    w(10);
    chk({31'h0, crp_n}, 32'h1);
    @(posedge core_clk);
    ctim_n <= 1'b1;
    w(DC + PC);
    chk({31'h0, crp_n}, 32'h1);
    apb(1'b0, COUNT_OFFSET, 32'h0);
    chk({16'h0, rd[15:0]}, 32'h2);
    apb(1'b1, CTRL_OFFSET, 32'h0);
    w(5);
    chk({31'h0, ton_n}, 32'h1);
    apb(1'b1, CTRL_OFFSET, 32'h1);
    w(5);
    chk({31'h0, ton_n}, 32'h0);
    // carrier gone: timeout drops dtr, then dsr off rearms the timer
    @(posedge core_clk);
    carrier <= 1'b0;
    wdtr(1'b1, HC + 50);
    chk(32'(n >= HC && n <= HC + 8), 32'h1);
    wdtr(1'b0, 20);
    chk(32'(n < 20), 32'h1);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    chk({31'h0, rd[ST_TIMER_OK_BIT]}, 32'h1);
    chr(8'h33, 1'b0);
    close_out;
  end
endmodule
